// ===== bto_consts.vh
// Constants shared by the bit-test, clear and compare execution unit.
`ifndef BTO_CONSTS_VH
`define BTO_CONSTS_VH

// ****************************************
// Operation codes on the issue port
// ****************************************
`define BTO_OP_W 3
`define BTO_OP_NOP 3'h0
`define BTO_OP_SKIP1 3'h1
`define BTO_OP_ZACC 3'h2
`define BTO_OP_ZFILE 3'h3
`define BTO_OP_INV 3'h4
`define BTO_OP_KICK 3'h5
`define BTO_OP_CMP 3'h6

// ****************************************
// Destination select values
// ****************************************
`define BTO_DEST_ACC 1'h0
`define BTO_DEST_FILE 1'h1

// ****************************************
// Register port map
// ****************************************
`define BTO_FILE_DEPTH 64
`define BTO_ADDR_FILE_MAX 8'h3f
`define BTO_ADDR_ACC 8'h40
`define BTO_ADDR_STATUS 8'h41
`define BTO_ADDR_CTRL 8'h42

// ****************************************
// Status and control field positions
// ****************************************
`define BTO_ST_CARRY 0
`define BTO_ST_ZERO 2
`define BTO_ST_PD 3
`define BTO_ST_TO 4
`define BTO_CTRL_DIV_WDT 0

// ****************************************
// Reset values
// ****************************************
`define BTO_RST_ACC 8'h00
`define BTO_RST_FILE 8'h00
`define BTO_RST_TO 1'h1
`define BTO_RST_PD 1'h1
`define BTO_RST_DIV_WDT 1'h1
`define BTO_ZERO_BYTE 8'h00

`endif

// ===== bto_alu.v
// Combinational result, flag and skip evaluation for one issued operation.
`timescale 1ns/100ps
`default_nettype none
`include "bto_consts.vh"

module bto_alu (
    // Operation
    input wire [2:0] op,
    input wire dest,
    input wire [2:0] bit_sel,
    // Operands
    input wire [7:0] fval,
    input wire [7:0] acc,
    // Results
    output reg [7:0] result,
    output reg wr_acc,
    output reg wr_file,
    output reg upd_zero,
    output reg upd_carry,
    output reg res_zero,
    output reg borrow_free,
    output reg skip,
    output reg kick
);

    reg [8:0] diff;

    always @* begin
        diff = {1'b0, fval} - {1'b0, acc};
        result = `BTO_ZERO_BYTE;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_zero = 1'b0;
        upd_carry = 1'b0;
        res_zero = 1'b0;
        borrow_free = 1'b0;
        skip = 1'b0;
        kick = 1'b0;
        case (op)
            `BTO_OP_SKIP1: begin
                skip = fval[bit_sel];
            end
            `BTO_OP_ZACC: begin
                wr_acc = 1'b1;
                upd_zero = 1'b1;
                res_zero = 1'b1;
            end
            `BTO_OP_ZFILE: begin
                wr_file = 1'b1;
                upd_zero = 1'b1;
                res_zero = 1'b1;
            end
            `BTO_OP_INV: begin
                result = ~fval;
                upd_zero = 1'b1;
                res_zero = (~fval == `BTO_ZERO_BYTE);
                wr_acc = (dest == `BTO_DEST_ACC);
                wr_file = (dest == `BTO_DEST_FILE);
            end
            `BTO_OP_KICK: begin
                kick = 1'b1;
            end
            `BTO_OP_CMP: begin
                // Difference only feeds the flags; nothing is written back.
                upd_zero = 1'b1;
                upd_carry = 1'b1;
                res_zero = (diff[7:0] == `BTO_ZERO_BYTE);
                borrow_free = ~diff[8];
            end
            default: begin
                result = `BTO_ZERO_BYTE;
            end
        endcase
    end

endmodule
`default_nettype wire

// ===== bto_skip_ctl.v
// Skip sequencer: squashes the instruction fetched after a taken skip.
`timescale 1ns/100ps
`default_nettype none
`include "bto_consts.vh"

module bto_skip_ctl (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Issue
    input wire instr_valid,
    input wire skip_req,
    // Control
    output wire exec_en,
    output wire squash
);

    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_SQUASH = 2'b10;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;

    // The fetched successor may arrive one or more cycles later; it is
    // discarded whenever it shows up, so the skip costs one slot.
    assign squash = state_ff[1] & instr_valid;
    assign exec_en = instr_valid & ~state_ff[1];

    always @* begin
        case (state_ff)
            ST_RUN: begin
                nxt_state = (exec_en & skip_req) ? ST_SQUASH : ST_RUN;
            end
            ST_SQUASH: begin
                nxt_state = instr_valid ? ST_RUN : ST_SQUASH;
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

endmodule
`default_nettype wire

// ===== bto_core.v
// Execution unit for bit-test skip, clears, invert, watchdog kick and compare.
//
// Summary of operation
// - Bit-test op skips the next instruction when the addressed file bit is one.
// - A taken skip discards the fetched successor whenever it arrives; the skip costs one slot.
// - Clear-working op loads zero into the working register and sets zero flag.
// - Clear-file op writes zero to the selected file register and sets zero flag.
// - Invert op complements the file register and sets zero flag from result.
// - Invert destination zero goes to working register, one back to file register.
// - Kick op clears watchdog counter, and the divider when assigned to watchdog.
// - Kick op sets both timeout and power-down status bits to one.
// - Compare computes file minus working register; updates zero and carry flags.
// - Compare discards its difference; working and file registers stay unchanged.
`timescale 1ns/100ps
`default_nettype none
`include "bto_consts.vh"

module bto_core (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Instruction issue
    input wire instr_valid,
    input wire [2:0] instr_op,
    input wire [5:0] instr_addr,
    input wire [2:0] instr_bit,
    input wire instr_dest,
    // Instruction status
    output wire instr_squashed,
    output reg skip_taken_ff,
    // Watchdog side
    output reg wdt_clear_ff,
    output reg divider_clear_ff,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_ff,
    // Visible state
    output reg [7:0] working_register_ff,
    output reg zero_flag_ff,
    output reg carry_flag_ff,
    output reg timeout_status_bit_ff,
    output reg powerdown_status_bit_ff
);

    // ****************************************
    // State
    // ****************************************
    reg [7:0] file_mem [0:`BTO_FILE_DEPTH-1];
    reg div_to_wdt_ff;
    integer i;

    wire exec_en;
    wire [7:0] fval;
    wire [7:0] alu_result;
    wire alu_wr_acc;
    wire alu_wr_file;
    wire alu_upd_zero;
    wire alu_upd_carry;
    wire alu_res_zero;
    wire alu_borrow_free;
    wire alu_skip;
    wire alu_kick;

    // ****************************************
    // Register port decode
    // ****************************************
    function is_file_addr;
        input [7:0] a;
        begin
            is_file_addr = (a <= `BTO_ADDR_FILE_MAX);
        end
    endfunction

    wire sw_wr_file = reg_wr & is_file_addr(reg_addr);
    wire sw_wr_acc = reg_wr & (reg_addr == `BTO_ADDR_ACC);
    wire sw_wr_status = reg_wr & (reg_addr == `BTO_ADDR_STATUS);
    wire sw_wr_ctrl = reg_wr & (reg_addr == `BTO_ADDR_CTRL);

    // ****************************************
    // Datapath
    // ****************************************
    assign fval = file_mem[instr_addr];

    bto_alu bto_alu_i (
        .op(instr_op),
        .dest(instr_dest),
        .bit_sel(instr_bit),
        .fval(fval),
        .acc(working_register_ff),
        .result(alu_result),
        .wr_acc(alu_wr_acc),
        .wr_file(alu_wr_file),
        .upd_zero(alu_upd_zero),
        .upd_carry(alu_upd_carry),
        .res_zero(alu_res_zero),
        .borrow_free(alu_borrow_free),
        .skip(alu_skip),
        .kick(alu_kick)
    );

    bto_skip_ctl bto_skip_ctl_i (
        .clk(clk),
        .rst_n(rst_n),
        .instr_valid(instr_valid),
        .skip_req(alu_skip),
        .exec_en(exec_en),
        .squash(instr_squashed)
    );

    wire ex_wr_acc = exec_en & alu_wr_acc;
    wire ex_wr_file = exec_en & alu_wr_file;
    wire ex_upd_zero = exec_en & alu_upd_zero;
    wire ex_upd_carry = exec_en & alu_upd_carry;
    wire ex_kick = exec_en & alu_kick;

    // ****************************************
    // File registers
    // ****************************************
    // An executing write wins over a software write in the same cycle.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `BTO_FILE_DEPTH; i = i + 1) begin
                file_mem[i] <= `BTO_RST_FILE;
            end
        end else begin
            if (sw_wr_file && !(ex_wr_file && reg_addr[5:0] == instr_addr)) begin
                file_mem[reg_addr[5:0]] <= reg_wdata;
            end
            if (ex_wr_file) begin
                file_mem[instr_addr] <= alu_result;
            end
        end
    end

    // ****************************************
    // Working register and flags
    // ****************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            working_register_ff <= `BTO_RST_ACC;
            zero_flag_ff <= 1'b0;
            carry_flag_ff <= 1'b0;
            timeout_status_bit_ff <= `BTO_RST_TO;
            powerdown_status_bit_ff <= `BTO_RST_PD;
            div_to_wdt_ff <= `BTO_RST_DIV_WDT;
        end else begin
            if (ex_wr_acc) begin
                working_register_ff <= alu_result;
            end else if (sw_wr_acc) begin
                working_register_ff <= reg_wdata;
            end
            if (ex_upd_zero) begin
                zero_flag_ff <= alu_res_zero;
            end else if (sw_wr_status) begin
                zero_flag_ff <= reg_wdata[`BTO_ST_ZERO];
            end
            if (ex_upd_carry) begin
                carry_flag_ff <= alu_borrow_free;
            end else if (sw_wr_status) begin
                carry_flag_ff <= reg_wdata[`BTO_ST_CARRY];
            end
            // A kick sets both bits and wins over a software clear.
            if (ex_kick) begin
                timeout_status_bit_ff <= 1'b1;
                powerdown_status_bit_ff <= 1'b1;
            end else if (sw_wr_status) begin
                timeout_status_bit_ff <= reg_wdata[`BTO_ST_TO];
                powerdown_status_bit_ff <= reg_wdata[`BTO_ST_PD];
            end
            if (sw_wr_ctrl) begin
                div_to_wdt_ff <= reg_wdata[`BTO_CTRL_DIV_WDT];
            end
        end
    end

    // ****************************************
    // Watchdog pulses and skip report
    // ****************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_clear_ff <= 1'b0;
            divider_clear_ff <= 1'b0;
            skip_taken_ff <= 1'b0;
        end else begin
            wdt_clear_ff <= ex_kick;
            divider_clear_ff <= ex_kick & div_to_wdt_ff;
            skip_taken_ff <= exec_en & alu_skip;
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    reg [7:0] rd_mux;

    always @* begin
        rd_mux = `BTO_ZERO_BYTE;
        if (is_file_addr(reg_addr)) begin
            rd_mux = file_mem[reg_addr[5:0]];
        end else if (reg_addr == `BTO_ADDR_ACC) begin
            rd_mux = working_register_ff;
        end else if (reg_addr == `BTO_ADDR_STATUS) begin
            rd_mux[`BTO_ST_CARRY] = carry_flag_ff;
            rd_mux[`BTO_ST_ZERO] = zero_flag_ff;
            rd_mux[`BTO_ST_PD] = powerdown_status_bit_ff;
            rd_mux[`BTO_ST_TO] = timeout_status_bit_ff;
        end else if (reg_addr == `BTO_ADDR_CTRL) begin
            rd_mux[`BTO_CTRL_DIV_WDT] = div_to_wdt_ff;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= `BTO_ZERO_BYTE;
        end else begin
            reg_rdata_ff <= reg_rd ? rd_mux : `BTO_ZERO_BYTE;
        end
    end

endmodule
`default_nettype wire

// ===== bto_core_properties.sv
// Concurrent checks on the execution unit ports.
`timescale 1ns/100ps
`default_nettype none
`include "bto_consts.vh"

module bto_core_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Issue
    input wire logic instr_valid,
    input wire logic [2:0] instr_op,
    input wire logic instr_dest,
    input wire logic instr_squashed,
    // Results
    input wire logic skip_taken_ff,
    input wire logic wdt_clear_ff,
    input wire logic divider_clear_ff,
    input wire logic [7:0] working_register_ff,
    input wire logic zero_flag_ff,
    input wire logic carry_flag_ff,
    input wire logic timeout_status_bit_ff,
    input wire logic powerdown_status_bit_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic go;
    assign go = instr_valid && !instr_squashed;

    AST_ZACC: assert property (
        go && instr_op == `BTO_OP_ZACC |=> working_register_ff == 8'h00 && zero_flag_ff)
        else $error("working clear gave nonzero or no zero flag");
    AST_ZFILE: assert property (
        go && instr_op == `BTO_OP_ZFILE |=> zero_flag_ff)
        else $error("file clear left zero flag low");
    AST_INV_ACC: assert property (
        go && instr_op == `BTO_OP_INV && instr_dest == `BTO_DEST_ACC
        |=> zero_flag_ff == (working_register_ff == 8'h00))
        else $error("invert zero flag disagrees with result");
    AST_KICK: assert property (
        go && instr_op == `BTO_OP_KICK
        |=> wdt_clear_ff && timeout_status_bit_ff && powerdown_status_bit_ff)
        else $error("kick missed clear pulse or status bits");
    AST_DIV: assert property (
        divider_clear_ff |-> wdt_clear_ff)
        else $error("divider cleared without watchdog clear");
    AST_SQUASH: assert property (
        skip_taken_ff && instr_valid |-> instr_squashed)
        else $error("successor of taken skip not discarded");
    AST_SKIP_FLAGS: assert property (
        go && instr_op == `BTO_OP_SKIP1
        |=> $stable({zero_flag_ff, carry_flag_ff, working_register_ff}))
        else $error("bit test changed state");
    AST_CMP_W: assert property (
        go && instr_op == `BTO_OP_CMP |=> $stable(working_register_ff))
        else $error("compare changed working register");
    AST_ONE_CYCLE: assert property (
        go && instr_op != `BTO_OP_SKIP1 |=> !skip_taken_ff)
        else $error("non skip op raised skip");
endmodule

bind bto_core bto_core_chk bto_core_chk_i (
    .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_dest(instr_dest), .instr_squashed(instr_squashed),
    .skip_taken_ff(skip_taken_ff), .wdt_clear_ff(wdt_clear_ff),
    .divider_clear_ff(divider_clear_ff), .working_register_ff(working_register_ff),
    .zero_flag_ff(zero_flag_ff), .carry_flag_ff(carry_flag_ff),
    .timeout_status_bit_ff(timeout_status_bit_ff),
    .powerdown_status_bit_ff(powerdown_status_bit_ff));
`default_nettype wire

// ===== bto_core_tb.sv
// Self-checking bench for the execution unit.
`timescale 1ns/100ps
`default_nettype none
`include "bto_consts.vh"

module bto_core_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [2:0] instr_op = 3'h0;
    logic [5:0] instr_addr = 6'h00;
    logic [2:0] instr_bit = 3'h0;
    logic instr_dest = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [7:0] reg_rdata_ff, working_register_ff;
    wire instr_squashed, skip_taken_ff, wdt_clear_ff, divider_clear_ff;
    wire zero_flag_ff, carry_flag_ff, timeout_status_bit_ff, powerdown_status_bit_ff;
    int err_total = 0;
    int num_checks = 0;
    logic [7:0] v;

    always #2 clk = ~clk;

    bto_core bto_core_i (
        .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_addr(instr_addr), .instr_bit(instr_bit), .instr_dest(instr_dest),
        .instr_squashed(instr_squashed), .skip_taken_ff(skip_taken_ff),
        .wdt_clear_ff(wdt_clear_ff), .divider_clear_ff(divider_clear_ff),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .working_register_ff(working_register_ff),
        .zero_flag_ff(zero_flag_ff), .carry_flag_ff(carry_flag_ff),
        .timeout_status_bit_ff(timeout_status_bit_ff),
        .powerdown_status_bit_ff(powerdown_status_bit_ff));

    // **********
    // Shared tasks
    // **********
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wrap_up;
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic drive(input logic [2:0] op, input logic [5:0] a, input logic [2:0] b,
            input logic d);
        instr_op <= op;
        instr_addr <= a;
        instr_bit <= b;
        instr_dest <= d;
        instr_valid <= 1'b1;
    endtask

    // Results are sampled at the falling edge of the cycle after issue.
    task automatic exec(input logic [2:0] op, input logic [5:0] a, input logic d);
        @(posedge clk);
        drive(op, a, 3'h0, d);
        @(posedge clk);
        instr_valid <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        q = reg_rdata_ff;
    endtask

    // **********
    // Scenarios
    // **********
    task automatic t_skip;
        for (int i = 0; i < 2; i++) begin
            wr(8'h03, i[0] ? 8'h08 : 8'hf7);
            wr(`BTO_ADDR_ACC, 8'h33);
            wr(`BTO_ADDR_STATUS, 8'h01);
            @(posedge clk);
            drive(`BTO_OP_SKIP1, 6'h03, 3'h3, 1'b0);
            @(posedge clk);
            drive(`BTO_OP_ZACC, 6'h00, 3'h0, 1'b0);
            @(negedge clk);
            check("skip", skip_taken_ff, i[0]);
            check("squash", instr_squashed, i[0]);
            check("zero", zero_flag_ff, 1'b0);
            check("carry", carry_flag_ff, 1'b1);
            @(posedge clk);
            instr_valid <= 1'b0;
            @(negedge clk);
            check("acc", working_register_ff, i[0] ? 8'h33 : 8'h00);
        end
    endtask

    task automatic t_zero;
        wr(`BTO_ADDR_ACC, 8'h55);
        wr(`BTO_ADDR_STATUS, 8'h00);
        exec(`BTO_OP_ZACC, 6'h00, 1'b0);
        check("acc", working_register_ff, 8'h00);
        check("zero", zero_flag_ff, 1'b1);
        wr(8'h05, 8'h55);
        wr(`BTO_ADDR_STATUS, 8'h00);
        exec(`BTO_OP_ZFILE, 6'h05, 1'b0);
        check("zero", zero_flag_ff, 1'b1);
        rd(8'h05, v);
        check("file", v, 8'h00);
    endtask

    task automatic t_inv;
        logic [7:0] f;
        for (int i = 0; i < 4; i++) begin
            f = i[1] ? 8'hff : 8'ha6;
            wr(8'h07, f);
            wr(`BTO_ADDR_ACC, 8'h11);
            wr(`BTO_ADDR_STATUS, i[1] ? 8'h00 : 8'h04);
            exec(`BTO_OP_INV, 6'h07, i[0]);
            check("zero", zero_flag_ff, ~f == 8'h00);
            check("acc", working_register_ff, i[0] ? 8'h11 : ~f);
            rd(8'h07, v);
            check("file", v, i[0] ? ~f : f);
        end
    endtask

    task automatic t_kick;
        for (int i = 0; i < 2; i++) begin
            wr(`BTO_ADDR_STATUS, 8'h00);
            wr(`BTO_ADDR_CTRL, i[0] ? 8'h01 : 8'h00);
            exec(`BTO_OP_KICK, 6'h00, 1'b0);
            check("wdt", wdt_clear_ff, 1'b1);
            check("div", divider_clear_ff, i[0]);
            check("to", timeout_status_bit_ff, 1'b1);
            check("pd", powerdown_status_bit_ff, 1'b1);
        end
    endtask

    task automatic t_cmp;
        logic [7:0] fv [4] = '{8'h34, 8'h12, 8'h12, 8'h00};
        logic [7:0] wv [4] = '{8'h12, 8'h12, 8'h34, 8'hff};
        for (int i = 0; i < 4; i++) begin
            wr(8'h09, fv[i]);
            wr(`BTO_ADDR_ACC, wv[i]);
            wr(`BTO_ADDR_STATUS, {5'h0, fv[i] != wv[i], 1'b0, fv[i] < wv[i]});
            exec(`BTO_OP_CMP, 6'h09, 1'b0);
            check("zero", zero_flag_ff, fv[i] == wv[i]);
            check("carry", carry_flag_ff, fv[i] >= wv[i]);
            check("acc", working_register_ff, wv[i]);
            rd(8'h09, v);
            check("file", v, fv[i]);
        end
    endtask

    // Reset state of the status and control words, and a kick with the reset divider owner.
    task automatic t_regs;
        rd(`BTO_ADDR_CTRL, v);
        check("ctrl", v, 8'h01);
        rd(`BTO_ADDR_STATUS, v);
        check("status", v, 8'h18);
        wr(`BTO_ADDR_STATUS, 8'h00);
        exec(`BTO_OP_KICK, 6'h00, 1'b0);
        check("div", divider_clear_ff, 1'b1);
        rd(`BTO_ADDR_STATUS, v);
        check("status", v, 8'h18);
    endtask

    // An idle cycle after a taken skip must not use up the squash.
    task automatic t_skip_gap;
        wr(8'h03, 8'h08);
        wr(`BTO_ADDR_ACC, 8'h33);
        @(posedge clk);
        drive(`BTO_OP_SKIP1, 6'h03, 3'h3, 1'b0);
        @(posedge clk);
        instr_valid <= 1'b0;
        @(posedge clk);
        drive(`BTO_OP_ZACC, 6'h00, 3'h0, 1'b0);
        @(negedge clk);
        check("squash", instr_squashed, 1'b1);
        @(posedge clk);
        instr_valid <= 1'b0;
        @(negedge clk);
        check("acc", working_register_ff, 8'h33);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_skip;
        t_skip_gap;
        t_zero;
        t_inv;
        t_kick;
        t_cmp;
        wrap_up;
    end

    initial begin
        #20000;
        err_total++;
        wrap_up;
    end
endmodule
`default_nettype wire
